/* File: design/rto_regs.v */
// Remote reading format, diode-model select and offset registers.
// Assumes the bus engine presents command-byte reads and writes as one-cycle strobes,
// and the converter delivers signed raw results with a one-cycle valid per channel.
`timescale 1ns/10ps
`include "rto_defines.vh"

module rto_regs (
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] i_cmd,
  input wire i_wr_stb,
  input wire [7:0] i_wr_data,
  input wire i_rd_stb,
  output reg [7:0] o_rd_data,
  output reg o_rd_ack,
  input wire [13:0] i_remote1_raw,
  input wire i_remote1_raw_valid,
  input wire [13:0] i_remote2_raw,
  input wire i_remote2_raw_valid,
  input wire [1:0] i_remote1_filter_setting,
  input wire [1:0] i_remote2_filter_setting,
  output reg o_remote1_beta_comp_select,
  output reg o_remote2_beta_comp_select
);

  reg remote1_beta_reg;
  reg remote2_beta_reg;
  reg [7:0] remote1_offset_reg;
  reg [7:0] remote2_offset_reg;
  reg [7:0] rd_data_next;
  wire [7:0] diode_model_value;
  wire [27:0] raw_all;
  wire [1:0] raw_valid_all;
  wire [15:0] offset_all;
  wire [25:0] reading_all;
  wire [12:0] remote1_reading;
  wire [12:0] remote2_reading;
  // Power-on value of the diode-model byte, kept whole so single bits can be picked from it.
  localparam [7:0] DIODE_RST = `RTO_DIODE_MODEL_RST;

  // Fraction byte: three fixed bits, two filter-only bits, three zero bits.
  function [7:0] frac_byte;
    input [12:0] reading;
    input [1:0] filter_setting;
    reg filt_on;
    begin
      filt_on = (filter_setting != `RTO_FILTER_OFF);
      frac_byte = {reading[4:2],
                   reading[1] & filt_on,
                   reading[0] & filt_on,
                   3'h0};
    end
  endfunction

  // Write strobe decode for one command byte.
  function wr_hit;
    input [7:0] cmd;
    input stb;
    input [7:0] target;
    begin
      wr_hit = stb && (cmd == target);
    end
  endfunction

  // Only the two model bits exist; the other bits are not stored at all.
  assign diode_model_value = {5'h00, remote2_beta_reg, remote1_beta_reg, 1'b0};

  // Diode-model select; a one picks the beta-compensated model.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      remote1_beta_reg <= DIODE_RST[`RTO_R1_BETA_BIT];
      remote2_beta_reg <= DIODE_RST[`RTO_R2_BETA_BIT];
    end else if (wr_hit(i_cmd, i_wr_stb, `RTO_CMD_DIODE_MODEL)) begin
      remote1_beta_reg <= i_wr_data[`RTO_R1_BETA_BIT];
      remote2_beta_reg <= i_wr_data[`RTO_R2_BETA_BIT];
    end
  end

  // Model selects drive the analog front end straight from flops.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_remote1_beta_comp_select <= DIODE_RST[`RTO_R1_BETA_BIT];
      o_remote2_beta_comp_select <= DIODE_RST[`RTO_R2_BETA_BIT];
    end else begin
      o_remote1_beta_comp_select <= remote1_beta_reg;
      o_remote2_beta_comp_select <= remote2_beta_reg;
    end
  end

  // Two's complement offset registers, full eight bits writable.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      remote1_offset_reg <= `RTO_OFFSET_RST;
      remote2_offset_reg <= `RTO_OFFSET_RST;
    end else begin
      if (wr_hit(i_cmd, i_wr_stb, `RTO_CMD_R1_OFFSET)) begin
        remote1_offset_reg <= i_wr_data;
      end
      if (wr_hit(i_cmd, i_wr_stb, `RTO_CMD_R2_OFFSET)) begin
        remote2_offset_reg <= i_wr_data;
      end
    end
  end

  // Pack per-channel signals so one generate loop serves both remotes.
  assign raw_all = {i_remote2_raw, i_remote1_raw};
  assign raw_valid_all = {i_remote2_raw_valid, i_remote1_raw_valid};
  assign offset_all = {remote2_offset_reg, remote1_offset_reg};

  // A new offset takes effect at the next conversion, never on a stored reading.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      rto_chan u_chan (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_raw(raw_all[ch*14 +: 14]),
        .i_raw_valid(raw_valid_all[ch]),
        .i_offset(offset_all[ch*8 +: 8]),
        .o_reading(reading_all[ch*13 +: 13])
      );
    end
  endgenerate

  assign remote1_reading = reading_all[12:0];
  assign remote2_reading = reading_all[25:13];

  // Read multiplexer; unmapped command bytes answer 0x00.
  always @* begin
    case (i_cmd)
      `RTO_CMD_R1_INT: rd_data_next = remote1_reading[12:5];
      `RTO_CMD_R2_INT: rd_data_next = remote2_reading[12:5];
      `RTO_CMD_R1_FRAC: rd_data_next = frac_byte(remote1_reading, i_remote1_filter_setting);
      `RTO_CMD_R2_FRAC: rd_data_next = frac_byte(remote2_reading, i_remote2_filter_setting);
      `RTO_CMD_DIODE_MODEL: rd_data_next = diode_model_value;
      `RTO_CMD_R1_OFFSET: rd_data_next = remote1_offset_reg;
      `RTO_CMD_R2_OFFSET: rd_data_next = remote2_offset_reg;
      default: rd_data_next = 8'h00;
    endcase
  end

  // Read data is registered one cycle after the strobe and held until the next read.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
      o_rd_ack <= 1'b0;
    end else begin
      o_rd_ack <= i_rd_stb;
      if (i_rd_stb) begin
        o_rd_data <= rd_data_next;
      end
    end
  end

endmodule

/* File: pkg/rto_defines.vh */
// Constants for the remote reading, offset and diode-model register block.
// Assumes a command-byte register port driven by the device's bus engine.
`ifndef RTO_DEFINES_VH
`define RTO_DEFINES_VH

// Command bytes.
`define RTO_CMD_R1_INT 8'h19
`define RTO_CMD_R2_INT 8'h1a
`define RTO_CMD_R1_FRAC 8'h29
`define RTO_CMD_R2_FRAC 8'h2a
`define RTO_CMD_DIODE_MODEL 8'h30
`define RTO_CMD_R1_OFFSET 8'h31
`define RTO_CMD_R2_OFFSET 8'h32

// Reset values.
`define RTO_DIODE_MODEL_RST 8'h02
`define RTO_OFFSET_RST 8'h00
`define RTO_READING_RST 13'h0000

// Diode-model field positions.
`define RTO_R1_BETA_BIT 1
`define RTO_R2_BETA_BIT 2

// Raw converter result: signed, 1/32 degree per LSB, 14 bits.
`define RTO_RAW_W 14
// Reported unsigned reading: 8 integer bits and 5 fraction bits.
`define RTO_READ_W 13
`define RTO_READ_MAX 13'h1fff
// Offset LSB is 1/2 degree, so it sits 4 bits above the 1/32 LSB.
`define RTO_OFFSET_SHIFT 4

// Filter code meaning all digital filtering off.
`define RTO_FILTER_OFF 2'h0

`endif

/* File: design/rto_chan.v */
// One remote channel: adds the offset to the raw result and clamps it.
// Assumes the raw result is signed, 1/32 degree per LSB, with a one-cycle valid.
`timescale 1ns/10ps
`include "rto_defines.vh"

module rto_chan (
  input wire i_clk,
  input wire i_rst_n,
  input wire signed [13:0] i_raw,
  input wire i_raw_valid,
  input wire signed [7:0] i_offset,
  output reg [12:0] o_reading
);

  wire signed [14:0] raw_ext;
  wire signed [14:0] offset_ext;
  wire signed [14:0] sum;
  reg [12:0] reading_next;

  // The offset byte covers -64..+63.5 degrees; scaled to 1/32 units it cannot overflow 15 bits.
  assign raw_ext = {i_raw[13], i_raw};
  assign offset_ext = {{3{i_offset[7]}}, i_offset, 4'h0};
  assign sum = raw_ext + offset_ext;

  // Clamp to the unsigned range so a hot diode never reads as cold after a wrap.
  always @* begin
    if (sum[14]) begin
      reading_next = `RTO_READING_RST;
    end else if (sum[13]) begin
      reading_next = `RTO_READ_MAX;
    end else begin
      reading_next = sum[12:0];
    end
  end

  // The reading updates only when a conversion result arrives.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reading <= `RTO_READING_RST;
    end else if (i_raw_valid) begin
      o_reading <= reading_next;
    end
  end

endmodule

/* File: test/rto_host.sv */
// Host model for the register port of the reading block.
// Assumes tasks are entered at a falling edge and return at one.
`timescale 1ns/10ps
module rto_host (
  input wire i_clk,
  output reg [7:0] o_cmd = 8'h00,
  output reg o_wr_stb = 1'b0,
  output reg [7:0] o_wr_data = 8'h00,
  output reg o_rd_stb = 1'b0,
  input wire [7:0] i_rd_data,
  input wire i_rd_ack
);
  // Write: one strobe cycle; stale data is inverted so nothing leans on it.
  task wr(input [7:0] c, input [7:0] w);
    o_cmd = c;
    o_wr_data = w;
    o_wr_stb = 1'b1;
    @(negedge i_clk);
    o_wr_stb = 1'b0;
    o_wr_data = ~w;
  endtask
  // Read: the answer stands in the cycle after the strobe edge.
  task rd(input [7:0] c, output [7:0] d, output k);
    o_cmd = c;
    o_rd_stb = 1'b1;
    @(negedge i_clk);
    d = i_rd_data;
    k = i_rd_ack;
    o_rd_stb = 1'b0;
  endtask
endmodule

/* File: test/rto_regs_properties.sv */
// Checker for the register port and diode-model outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module rto_regs_properties (
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] i_cmd,
  input wire i_wr_stb,
  input wire [7:0] i_wr_data,
  input wire i_rd_stb,
  input wire [7:0] o_rd_data,
  input wire o_rd_ack,
  input wire [1:0] i_remote1_filter_setting,
  input wire o_remote1_beta_comp_select,
  input wire o_remote2_beta_comp_select
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  read_answer_a: assert property (i_rd_stb |=> o_rd_ack) else $error("no ack");
  no_stray_ack_a: assert property (!i_rd_stb |=> !o_rd_ack) else $error("stray ack");
  data_hold_a: assert property (!i_rd_stb |=> $stable(o_rd_data)) else $error("data moved");
  diode_reserved_a: assert property (i_rd_stb && i_cmd == 8'h30 |=>
    o_rd_data[7:3] == 5'h00 && !o_rd_data[0]) else $error("diode reserved");
  frac_reserved_a: assert property (i_rd_stb && (i_cmd == 8'h29 || i_cmd == 8'h2a) |=>
    o_rd_data[2:0] == 3'h0) else $error("frac reserved");
  filter_off_a: assert property (i_rd_stb && i_cmd == 8'h29 && i_remote1_filter_setting == 2'h0 |=>
    o_rd_data[4:3] == 2'h0) else $error("filter bits");
  // The select outputs stand two edges after the write edge, before a following write can land.
  beta1_follow_a: assert property (i_wr_stb && i_cmd == 8'h30 |-> ##2
    o_remote1_beta_comp_select == $past(i_wr_data[1], 2)) else $error("beta1");
  beta2_follow_a: assert property (i_wr_stb && i_cmd == 8'h30 |-> ##2
    o_remote2_beta_comp_select == $past(i_wr_data[2], 2)) else $error("beta2");
  offset_readback_a: assert property (i_wr_stb && i_cmd == 8'h31 ##1 i_rd_stb && i_cmd == 8'h31 |=>
    o_rd_data == $past(i_wr_data, 2)) else $error("offset readback");
  unmapped_read_a: assert property (i_rd_stb && i_cmd == 8'hff |=> o_rd_data == 8'h00) else $error("unmapped");
endmodule
bind rto_regs rto_regs_properties chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .i_wr_stb(i_wr_stb),
  .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_rd_ack(o_rd_ack),
  .i_remote1_filter_setting(i_remote1_filter_setting), .o_remote1_beta_comp_select(o_remote1_beta_comp_select),
  .o_remote2_beta_comp_select(o_remote2_beta_comp_select));

/* File: test/rto_regs_tb.sv */
// Self-checking bench for the reading, offset and diode-model registers.
// Assumes a 250 MHz clock and the host model on the register port.
`timescale 1ns/10ps
module rto_regs_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] cmd, wr_data, rd_data, d;
  logic wr_stb, rd_stb, rd_ack, k, b1, b2;
  logic [13:0] raw = 14'h0000;
  logic v = 1'b0;
  logic [1:0] f = 2'h0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // Rows: command, write data, expected read back.
  logic [23:0] rows [0:10] = '{24'h30ff06, 24'h300000, 24'h300404, 24'h317f7f, 24'h318080, 24'h320101,
    24'h195500, 24'h2a5500, 24'hff1200, 24'h310000, 24'h320000};
  // Free-running clock.
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  rto_host host_u (.i_clk(i_clk), .o_cmd(cmd), .o_wr_stb(wr_stb), .o_wr_data(wr_data), .o_rd_stb(rd_stb),
    .i_rd_data(rd_data), .i_rd_ack(rd_ack));
  // Both channels see the same conversion so each offset path is used.
  rto_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .i_wr_stb(wr_stb), .i_wr_data(wr_data),
    .i_rd_stb(rd_stb), .o_rd_data(rd_data), .o_rd_ack(rd_ack), .i_remote1_raw(raw), .i_remote1_raw_valid(v),
    .i_remote2_raw(raw), .i_remote2_raw_valid(v), .i_remote1_filter_setting(f), .i_remote2_filter_setting(f),
    .o_remote1_beta_comp_select(b1), .o_remote2_beta_comp_select(b2));
  task chk(input [7:0] c, input [7:0] e, input [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR cmd %h expected %h seen %h", c, e, g);
    end
  endtask
  // Reads a byte; a missing ack is a mismatch too.
  task rdchk(input [7:0] c, input [7:0] e);
    host_u.rd(c, d, k);
    chk(c, e, (k === 1'b1) ? d : 8'hxx);
  endtask
  // Program an offset, convert, then read integer and fraction back to back.
  task conv(input [7:0] oc, input [7:0] off, input [13:0] r, input [1:0] fs, input [7:0] ei, input [7:0] ef);
    host_u.wr(oc, off);
    raw = r;
    f = fs;
    v = 1'b1;
    @(negedge i_clk);
    v = 1'b0;
    rdchk(oc[1] ? 8'h1a : 8'h19, ei);
    rdchk(oc[1] ? 8'h2a : 8'h29, ef);
  endtask
  task wrap_up;
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 55 cycles the run needs.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk(8'h30, 8'h02, {5'h00, b2, b1, 1'b0});
    rdchk(8'h30, 8'h02);
    rdchk(8'h31, 8'h00);
    rdchk(8'h32, 8'h00);
    foreach (rows[n]) begin
      host_u.wr(rows[n][23:16], rows[n][15:8]);
      rdchk(rows[n][23:16], rows[n][7:0]);
    end
    chk(8'h30, 8'h04, {5'h00, b2, b1, 1'b0});
    conv(8'h31, 8'h04, 14'h0c80, 2'h0, 8'h66, 8'h00);
    conv(8'h32, 8'h00, 14'h0c9f, 2'h3, 8'h64, 8'hf8);
    conv(8'h32, 8'h00, 14'h0c9f, 2'h1, 8'h64, 8'hf8);
    conv(8'h31, 8'h00, 14'h0c9f, 2'h0, 8'h64, 8'he0);
    conv(8'h31, 8'h7f, 14'h1ff0, 2'h3, 8'hff, 8'hf8);
    conv(8'h32, 8'h80, 14'h0c80, 2'h0, 8'h24, 8'h00);
    conv(8'h31, 8'h00, 14'h3c00, 2'h3, 8'h00, 8'h00);
    wrap_up();
  end
endmodule
